// *** src/wkd_pkg.sv ***
package wkd_pkg;
  localparam int unsigned CLK_MHZ             = 250;
  localparam int unsigned SHORT_FILTER_US     = 16;
  localparam int unsigned LONG_FILTER_US      = 64;
  localparam int unsigned SHORT_FILTER_CYC    = SHORT_FILTER_US * CLK_MHZ;
  localparam int unsigned LONG_FILTER_CYC     = LONG_FILTER_US * CLK_MHZ;
  localparam int unsigned NUM_WAKE            = 3;
  localparam int unsigned NUM_ALT             = 2;

  // filter_config_control codes
  localparam logic [1:0] FLT_STATIC_SHORT     = 2'h0;
  localparam logic [1:0] FLT_STATIC_LONG      = 2'h1;
  localparam logic [1:0] FLT_CYCLIC_A         = 2'h2;
  localparam logic [1:0] FLT_CYCLIC_B         = 2'h3;
  // pull_source_control codes
  localparam logic [1:0] PULL_NONE            = 2'h0;
  localparam logic [1:0] PULL_DOWN            = 2'h1;
  localparam logic [1:0] PULL_UP              = 2'h2;
  localparam logic [1:0] PULL_AUTO            = 2'h3;
  localparam logic [1:0] PULL_RESET           = 2'h0;

  typedef enum logic [1:0] {
    WKD_MODE_NORMAL,
    WKD_MODE_STOP,
    WKD_MODE_SLEEP,
    WKD_MODE_FAILSAFE
  } wkd_mode_t;

  typedef struct packed {
    logic       enable;
    logic [1:0] pull_cfg;
    logic [1:0] filter_cfg;
  } wkd_chan_cfg_t;

  typedef struct packed {
    logic pull_up_en;
    logic pull_down_en;
  } wkd_pull_t;
endpackage : wkd_pkg

// *** src/wkd_chan.sv ***
`timescale 1ns/10ps
module wkd_chan
  import wkd_pkg::*;
#(
  parameter int unsigned SHORT_CYC = SHORT_FILTER_CYC,
  parameter int unsigned LONG_CYC  = LONG_FILTER_CYC
) (
  input  wire logic  i_sys_clk,   // system clock
  input  wire logic  i_arst_n,    // async reset, active low
  input  wire logic  i_pin,       // raw comparator output
  input  wire logic  i_window,    // evaluation allowed
  input  wire logic  i_long,      // use long filter
  output logic       o_level,     // synchronised filtered-free level
  output logic       o_event      // one-cycle recognised edge
);
  localparam int unsigned CW = $clog2(LONG_CYC + 1);

  // refuse counts that the filter counter cannot serve
  if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC) begin : g_bad_cyc
    $error("wkd_chan: bad filter counts");
  end

  logic          sync1;
  logic          sync2;
  logic          stable;
  logic          running;
  logic [CW-1:0] count;
  logic [CW-1:0] limit;

  assign limit = i_long ? CW'(LONG_CYC) : CW'(SHORT_CYC);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= i_pin;
      sync2 <= sync1;
    end
  end

  assign o_level = sync2;

  // either edge starts filter, cross-back aborts
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stable  <= 1'b0;
      running <= 1'b0;
      count   <= '0;
      o_event <= 1'b0;
    end else begin
      o_event <= 1'b0;
      if (!i_window) begin
        running <= 1'b0;
        count   <= '0;
      end else if (sync2 == stable) begin
        running <= 1'b0;
        count   <= '0;
      end else if (!running) begin
        running <= 1'b1;
        count   <= CW'(1);
      end else if (count >= limit) begin
        running <= 1'b0;
        count   <= '0;
        stable  <= sync2;
        o_event <= 1'b1;
      end else begin
        count <= count + CW'(1);
      end
      if (!i_window)
        stable <= sync2;
    end
  end
endmodule : wkd_chan

// *** src/wkd_detector.sv ***
`timescale 1ns/10ps
module wkd_detector
  import wkd_pkg::*;
#(
  parameter int unsigned SHORT_CYC = SHORT_FILTER_CYC,
  parameter int unsigned LONG_CYC  = LONG_FILTER_CYC
) (
  input  wire logic            i_sys_clk,        // system clock
  input  wire logic            i_arst_n,         // async reset, active low
  input  wire wkd_mode_t       i_mode,           // device operating mode
  input  wire logic [2:0]      i_wake_pin,       // pin one..three comparators
  input  wire logic [1:0]      i_fo_pin,         // fail-safe pins two, three
  input  wire logic [1:0]      i_fo_wake_en,     // fail-safe pins as wake
  input  wire wkd_chan_cfg_t [2:0] i_cfg,        // per-channel settings
  input  wire logic            i_timer_a_on,     // timer a on-time window
  input  wire logic            i_timer_b_on,     // timer b on-time window
  input  wire logic            i_meas_en,        // measure function enable
  input  wire logic [2:0]      i_src_clr,        // clear wake-source flags
  input  wire logic [1:0]      i_alt_clr,        // clear alt-pin flags
  output logic [2:0]           o_wake_source,    // wake_source_status
  output logic [1:0]           o_alt_status,     // alt_pin_wake_status
  output logic [2:0]           o_level_status,   // pin_level_status
  output wkd_pull_t [2:0]      o_pull,           // pull source enables
  output logic                 o_interrupt,      // wake interrupt pulse
  output logic                 o_wakeup          // device wake-up pulse
);
  // refuse counts that the filter counter cannot serve
  if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC) begin : g_bad_cyc
    $error("wkd_detector: bad filter counts");
  end
  // the pin ports are fixed at three wake and two fail-safe pins
  if (NUM_WAKE != 3 || NUM_ALT != 2) begin : g_bad_num
    $error("wkd_detector: channel counts do not match ports");
  end

  logic [2:0]      lvl;
  logic [2:0]      evt;
  logic [2:0]      window;
  logic [2:0]      cyclic;
  logic [2:0]      long_sel;
  logic [2:0]      enable;
  logic [2:0]      gated;
  logic [2:0]      lvl_upd;
  logic [1:0]      alt_evt;
  logic [2:0]      hit;
  logic            any_hit;
  logic            active_mode;
  wkd_pull_t [2:0] next_pull;
  logic [2:0]      next_level_status;
  logic [2:0]      next_wake_source;
  logic [1:0]      next_alt_status;
  logic            next_interrupt;
  logic            next_wakeup;

  // measure function gates pins one and two
  assign gated = {1'b0, {2{i_meas_en}}};
  // a mode change steers only events recognised after it
  assign active_mode = (i_mode == WKD_MODE_NORMAL) ||
                       (i_mode == WKD_MODE_STOP);

  for (genvar g = 0; g < NUM_WAKE; g++) begin : g_chan
    // filter code selects window and time
    always_comb begin
      cyclic[g]   = i_cfg[g].filter_cfg[1];
      long_sel[g] = i_cfg[g].filter_cfg == FLT_STATIC_LONG;
      case (i_cfg[g].filter_cfg)
        FLT_CYCLIC_A: window[g] = i_timer_a_on;
        FLT_CYCLIC_B: window[g] = i_timer_b_on;
        default:      window[g] = 1'b1;
      endcase
    end

    wkd_chan #(
      .SHORT_CYC (SHORT_CYC),
      .LONG_CYC  (LONG_CYC)
    ) u_chan (
      .i_sys_clk (i_sys_clk),
      .i_arst_n  (i_arst_n),
      .i_pin     (i_wake_pin[g]),
      .i_window  (window[g]),
      .i_long    (long_sel[g]),
      .o_level   (lvl[g]),
      .o_event   (evt[g])
    );

    // each pin carries its own wake enable
    assign enable[g] = i_cfg[g].enable;

    always_comb begin
      next_pull[g] = '0;
      if (!gated[g]) begin
        case (i_cfg[g].pull_cfg)
          PULL_DOWN: begin
            next_pull[g].pull_down_en = 1'b1;
          end
          PULL_UP: begin
            next_pull[g].pull_up_en = 1'b1;
          end
          // follows the synchronised level, so it lags the pin
          PULL_AUTO: begin
            next_pull[g].pull_up_en   = lvl[g];
            next_pull[g].pull_down_en = !lvl[g];
          end
          default: begin
            next_pull[g] = '0;
          end
        endcase
      end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        o_pull[g] <= '0;
      end else begin
        o_pull[g] <= next_pull[g];
      end
    end

    // live level, or sample held in on-time
    assign lvl_upd[g] = active_mode && !gated[g] &&
                        (!cyclic[g] || window[g]);

    // outside the window the last on-time sample is kept
    always_comb begin
      next_level_status[g] = o_level_status[g];
      if (lvl_upd[g]) begin
        next_level_status[g] = lvl[g];
      end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        o_level_status[g] <= 1'b0;
      end else begin
        o_level_status[g] <= next_level_status[g];
      end
    end
  end

  // fail-safe pins use fixed short filter, static
  for (genvar a = 0; a < NUM_ALT; a++) begin : g_alt
    // the level of these pins is not reported, so it is left open
    wkd_chan #(
      .SHORT_CYC (SHORT_CYC),
      .LONG_CYC  (LONG_CYC)
    ) u_alt (
      .i_sys_clk (i_sys_clk),
      .i_arst_n  (i_arst_n),
      .i_pin     (i_fo_pin[a]),
      .i_window  (i_fo_wake_en[a]),
      .i_long    (1'b0),
      .o_level   (),
      .o_event   (alt_evt[a])
    );
  end

  // per-pin enable, gated pins never wake
  assign hit     = evt & enable & ~gated;
  assign any_hit = (|hit) || (|alt_evt);

  // sticky flags; an event beats a clear in one cycle
  always_comb begin
    next_wake_source = (o_wake_source & ~i_src_clr) | hit;
    next_alt_status  = (o_alt_status & ~i_alt_clr) | alt_evt;
  end

  always_comb begin
    next_interrupt = any_hit && active_mode;
    next_wakeup    = any_hit && !active_mode;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wake_source <= '0;
    end else begin
      o_wake_source <= next_wake_source;
    end
  end

  // alt-pin events in their own status
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_alt_status <= '0;
    end else begin
      o_alt_status <= next_alt_status;
    end
  end

  // one-cycle pulses, kind chosen by mode
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_interrupt <= 1'b0;
      o_wakeup    <= 1'b0;
    end else begin
      o_interrupt <= next_interrupt;
      o_wakeup    <= next_wakeup;
    end
  end
endmodule : wkd_detector

// *** test/wkd_detector_asserts.sv ***
`timescale 1ns/10ps
module wkd_asserts
  import wkd_pkg::*;
(
  input wire logic                i_sys_clk,     // clock
  input wire logic                i_arst_n,      // reset
  input wire wkd_mode_t           i_mode,        // mode
  input wire wkd_chan_cfg_t [2:0] i_cfg,         // config
  input wire logic                i_meas_en,     // gating
  input wire logic [2:0]          o_wake_source, // flags
  input wire logic [1:0]          o_alt_status,  // alt flags
  input wire logic [2:0]          o_level_status, // levels
  input wire wkd_pull_t [2:0]     o_pull,        // pulls
  input wire logic                o_interrupt,   // irq
  input wire logic                o_wakeup       // wake
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_gated;
    i_meas_en [*2];
  endsequence
  chk_irq_mode: assert property (
    o_interrupt |-> !$past(i_mode[1])) else $error("irq in sleep");
  chk_wake_mode: assert property (
    o_wakeup |-> $past(i_mode[1])) else $error("wake-up in run mode");
  chk_one_kind: assert property (
    !(o_interrupt && o_wakeup)) else $error("irq with wake-up");
  chk_src_pulse: assert property (
    (o_wake_source & ~$past(o_wake_source)) != 3'h0 |->
      o_interrupt || o_wakeup) else $error("flag without pulse");
  chk_alt_pulse: assert property (
    (o_alt_status & ~$past(o_alt_status)) != 2'h0 |->
      o_interrupt || o_wakeup) else $error("alt flag no pulse");
  chk_meas_pull: assert property (
    i_meas_en |=> o_pull[1:0] == 4'h0) else $error("gated pull");
  chk_meas_flag: assert property (
    s_gated |-> !$rose(o_wake_source[0]) && !$rose(o_wake_source[1]))
    else $error("gated flag set");
  chk_meas_level: assert property (
    i_meas_en |=> $stable(o_level_status[1:0]))
    else $error("gated level moved");
  chk_pull_up: assert property (
    i_cfg[2].pull_cfg == PULL_UP |=> o_pull[2] == 2'h2)
    else $error("pull-up code");
endmodule : wkd_asserts
bind wkd_detector wkd_asserts u_chk (.i_sys_clk, .i_arst_n, .i_mode,
  .i_cfg, .i_meas_en, .o_wake_source, .o_alt_status, .o_level_status,
  .o_pull,
  .o_interrupt, .o_wakeup);

// *** test/wkd_switch.sv ***
`timescale 1ns/10ps
module wkd_switch
  import wkd_pkg::*;
(
  input  wire logic            i_sys_clk, // clock
  input  wire logic [2:0]      i_drv,     // switch closed
  input  wire logic [2:0]      i_val,     // switched level
  input  wire wkd_pull_t [2:0] i_pull,    // device pulls
  output logic [2:0]           o_pin      // pin levels
);
  logic [2:0] last = 3'h0;
  always_ff @(posedge i_sys_clk) begin
    last <= o_pin;
  end
  // open pin with no pull wanders, so no stale level is trusted
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      o_pin[k] = i_drv[k] ? i_val[k] : i_pull[k].pull_up_en ? 1'b1 :
                 (i_pull[k].pull_down_en ? 1'b0 : ~last[k]);
    end
  end
endmodule : wkd_switch

// *** test/wkd_detector_tb.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  err_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module wkd_detector_tb
  import wkd_pkg::*;
();
  logic                clk = 1'b0, arst_n = 1'b0, meas = 1'b0;
  logic                ta = 1'b0, tb = 1'b0, irq, wu;
  logic [1:0]          fo = 2'h0, fo_en = 2'h0, aclr = 2'h0, alt;
  logic [2:0]          drv = 3'h7, val = 3'h0, clr = 3'h0, pin, src, lvl;
  wkd_mode_t           mode = WKD_MODE_NORMAL;
  wkd_chan_cfg_t [2:0] cfg = {3{5'h10}};
  wkd_pull_t [2:0]     pull;
  int                  err_count = 0, check_count = 0, irq_n = 0, wu_n = 0;
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    irq_n <= irq_n + int'(irq === 1'b1);
    wu_n  <= wu_n + int'(wu === 1'b1);
  end
  wkd_detector #(.SHORT_CYC(8), .LONG_CYC(32)) dut (.i_sys_clk(clk),
    .i_arst_n(arst_n), .i_mode(mode), .i_wake_pin(pin), .i_fo_pin(fo),
    .i_fo_wake_en(fo_en), .i_cfg(cfg), .i_timer_a_on(ta),
    .i_timer_b_on(tb), .i_meas_en(meas), .i_src_clr(clr),
    .i_alt_clr(aclr), .o_wake_source(src), .o_alt_status(alt),
    .o_level_status(lvl), .o_pull(pull), .o_interrupt(irq),
    .o_wakeup(wu));
  wkd_switch sw (.i_sys_clk(clk), .i_drv(drv), .i_val(val),
    .i_pull(pull), .o_pin(pin));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // 40 cycles covers the short filter plus pipeline with margin
  task automatic flip(input int ch, input int n);
    val[ch] <= ~val[ch];
    tick(n);
  endtask : flip
  task automatic clear();
    clr  <= 3'h7;
    aclr <= 2'h3;
    tick(1);
    clr  <= 3'h0;
    aclr <= 2'h0;
  endtask : clear
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    tick(2000);
    err_count++;
    stop_test();
  end
  initial begin
    tick(6);
    arst_n <= 1'b1;
    tick(20);
    flip(2, 40);
    `CHK("src", 3'h4, src)
    mode <= WKD_MODE_STOP;
    flip(2, 40);
    flip(2, 3);
    flip(2, 40);
    `CHK("irq", 2, irq_n)
    mode <= WKD_MODE_NORMAL;
    clear();
    cfg[1].filter_cfg <= FLT_STATIC_LONG;
    cfg[0].enable <= 1'b0;
    flip(1, 20);
    flip(1, 60);
    `CHK("src", 3'h0, src)
    flip(1, 60);
    flip(0, 40);
    `CHK("src", 3'h2, src)
    `CHK("lvl", 3'h3, lvl)
    $display("test static done");
    cfg[0] <= '{1'b1, PULL_NONE, FLT_CYCLIC_A};
    clear();
    flip(0, 40);
    `CHK("lvl", 3'h3, lvl)
    tb <= 1'b1;
    flip(0, 40);
    `CHK("src", 3'h0, src)
    tb <= 1'b0;
    ta <= 1'b1;
    flip(0, 40);
    `CHK("src", 3'h1, src)
    `CHK("lvl", 3'h2, lvl)
    ta <= 1'b0;
    cfg[0].filter_cfg <= FLT_CYCLIC_B;
    tb <= 1'b1;
    clear();
    flip(0, 40);
    `CHK("src", 3'h1, src)
    tb <= 1'b0;
    mode <= WKD_MODE_SLEEP;
    flip(2, 40);
    mode <= WKD_MODE_FAILSAFE;
    flip(2, 40);
    `CHK("wu", 2, wu_n)
    `CHK("irq", 5, irq_n)
    $display("test cyclic done");
    mode <= WKD_MODE_NORMAL;
    meas <= 1'b1;
    cfg[1].pull_cfg <= PULL_UP;
    clear();
    flip(1, 60);
    `CHK("src", 3'h0, src)
    meas <= 1'b0;
    fo_en <= 2'h3;
    fo <= 2'h3;
    tick(40);
    `CHK("alt", 2'h3, alt)
    clear();
    tick(1);
    `CHK("alt", 2'h0, alt)
    for (int k = 0; k < 3; k++) begin
      cfg[2].pull_cfg <= 2'(k);
      tick(2);
      `CHK("pull", 2'(k), pull[2])
    end
    cfg[2].pull_cfg <= PULL_AUTO;
    flip(2, 40);
    drv[2] <= 1'b0;
    tick(40);
    `CHK("pull", 2'h2, pull[2])
    drv[2] <= 1'b1;
    flip(2, 40);
    `CHK("pull", 2'h1, pull[2])
    $display("test pulls done");
    stop_test();
  end
endmodule : wkd_detector_tb
